// *** mac_model.sv ***
// MAC transmit model standing at the MII side of the mode block.
// Assumes link_clk runs free; one frame is one 32-bit word, low nibble first,
// or in RMII sixteen dibits, low dibit first.
`timescale 1ns/100ps
module mac_model (
  input  wire logic        link_clk,
  input  wire logic        rmii,
  input  wire logic        go,
  input  wire logic [31:0] word,
  input  wire logic [3:0]  err_pos,
  output logic             tx_en,
  output logic             tx_er,
  output logic      [3:0]  tx_d,
  output logic             busy
);
  logic [4:0] idx_r;

  // Idle state at time zero
  initial
  begin
    tx_en = 1'b0;
    tx_er = 1'b0;
    tx_d  = 4'h0;
    busy  = 1'b0;
    idx_r = 5'h00;
  end

  // enable framing, error only with enable
  // RMII enable stands only over the frame dibits; no error line there
  always @(posedge link_clk)
  begin
    if (busy && idx_r < (rmii ? 5'h10 : 5'h08))
    begin
      tx_en <= 1'b1;
      tx_er <= !rmii && (idx_r == {1'b0, err_pos});
      tx_d  <= rmii ? {2'h0, 2'(word >> (idx_r * 2))} : 4'(word >> (idx_r * 4));
      idx_r <= idx_r + 5'h01;
    end
    else
    begin
      tx_en <= 1'b0;
      tx_er <= 1'b0;
      tx_d  <= ~tx_d;  // Toggle between frames so stale data never looks valid
      busy  <= go;
      idx_r <= 5'h00;
    end
  end
endmodule : mac_model

// *** t1_phy_mode.sv ***
// Mode control and MII/RMII port of a single-pair 100 Mbit/s PHY.
// Assumes the management framer drives the register strobes on sys_clk,
// the PCS drives the line_* and pair inputs on link_clk.
// Behaviour
// - Reset on power-up, reset pin held low, or basic control bit 15.
// - Reset clears all logic and returns registers to defaults.
// - On reset completion straps are sampled into their register fields.
// - Managed master with supplies enters standby after power-up and reset.
// - Standby disables PCS/PMA, blocks data, keeps management and registers.
// - Autonomous strap goes to normal mode after reset and starts linking.
// - Managed master leaves standby on a management command, enabling PCS/PMA.
// - Writing autonomous control bit 6 switches to autonomous operation.
// - Role strap defaults to slave; a pulled-up pin selects master.
// - Role control bit 14 set means master, clear means slave.
// - Slave detects reversed polarity in training and inverts its transmit.
// - Polarity control register can disable automatic polarity correction.
// - Receive data state past the jabber timer returns to idle.
// - Jabber timer defaults to 1.1 ms, programmable by an 11-bit field.
// - Detect partner pair order A-B or B-A and de-interleave to match.
// - MII exchanges one 4-bit nibble per clock each way.
// - MII receive codes: errored data, false carrier 1110, idle 0000.
// - RMII moves two bits per clock each way on one 50 MHz clock.
// - RMII master runs from 25 MHz and drives 50 MHz on data bit 3.
// - RMII slave captures and launches dibits on the reference rising edge.
// - RMII also provides a separate receive valid and receive error.
`timescale 1ns/100ps
module t1_phy_mode #(
  parameter int LINK_MHZ = 25
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        reset_n_pin,
  input  wire logic        supplies_ok,
  input  wire logic        role_strap_pin,
  input  wire logic        auto_strap_pin,
  input  wire logic        rmii_strap_pin,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  output logic             pcs_en,
  input  wire logic        link_clk,
  input  wire logic        tx_en,
  input  wire logic        tx_er,
  input  wire logic [3:0]  tx_d,
  output logic             rx_dv,
  output logic             rx_er,
  output logic             crs_dv,
  output logic      [3:0]  rx_d,
  output logic             rx_d3_clk_en,
  output logic      [3:0]  pcs_tx_nib,
  output logic             pcs_tx_en,
  output logic             pcs_tx_er,
  output logic             pcs_tx_stb,
  input  wire logic        line_stb,
  input  wire logic        line_ssd,
  input  wire logic        line_esd,
  input  wire logic        line_err,
  input  wire logic        line_fc,
  input  wire logic [3:0]  line_nib,
  input  wire logic        train_active,
  input  wire logic [3:0]  rx_pair_in,
  output logic      [3:0]  rx_pair_out,
  input  wire logic [3:0]  tx_pair_in,
  output logic      [3:0]  tx_pair_out
);

  // Jabber count must fit 17 bits at the link rate
  if (LINK_MHZ < 1 || LINK_MHZ > 50)
  begin : g_chk
    $error("LINK_MHZ out of range");
  end

  // Ternary negation: +1 and -1 swap, zero stays
  function automatic logic [1:0] neg_sym(input logic [1:0] s);
    neg_sym = {s[1] ^ s[0], s[0]};
  endfunction : neg_sym

  logic [4:0]  pin1_r;
  logic [4:0]  pin2_r;
  logic [7:0]  low_cnt_r;
  logic [4:0]  hold_r;
  tp::mode_t   mode_r;
  logic        auto_r;
  logic        role_r;
  logic        rmii_r;
  logic        apdis_r;
  logic [10:0] jab_r;
  logic [1:0]  back1_r;
  logic [1:0]  back2_r;
  logic        pin_rst;
  logic        rst_src;
  logic        rst_done;
  logic        wr_ok;
  logic        soft_wr;
  logic        go_wr;

  // Pins come from outside the clock domain: two flops first
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pin1_r <= tp::PIN_RST;
      pin2_r <= tp::PIN_RST;
    end
    else
    begin
      pin1_r <= {supplies_ok, reset_n_pin, rmii_strap_pin,
                 auto_strap_pin, role_strap_pin};
      pin2_r <= pin1_r;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset || pin2_r[tp::I_RSTN])
      low_cnt_r <= 8'h00;
    else if (!pin_rst)
      low_cnt_r <= low_cnt_r + 8'h01;
  end

  assign pin_rst  = (low_cnt_r == tp::RST_MIN_CYC);
  assign wr_ok    = reg_wr && (mode_r != tp::M_RESET);
  assign soft_wr  = wr_ok && (reg_addr == tp::OFS_BASIC) && reg_wdata[tp::B_SRST];
  assign go_wr    = wr_ok && (reg_addr == tp::OFS_AUTO)
                    && (reg_wdata[tp::B_GO] || reg_wdata[tp::B_AUTO]);
  assign rst_src  = pin_rst || !pin2_r[tp::I_SUP] || soft_wr;
  assign rst_done = (mode_r == tp::M_RESET) && !rst_src && (hold_r == tp::RST_HOLD);

  // Reset is held a fixed time after the last source goes away
  always_ff @(posedge sys_clk)
  begin
    if (reset || rst_src || mode_r != tp::M_RESET)
      hold_r <= 5'h00;
    else if (hold_r != tp::RST_HOLD)
      hold_r <= hold_r + 5'h01;
  end

  // Operating mode
  always_ff @(posedge sys_clk)
  begin
    if (reset || rst_src)
      mode_r <= tp::M_RESET;
    else
      case (mode_r)
        tp::M_RESET:
          if (rst_done)
            mode_r <= (pin2_r[tp::I_AUTO] || !pin2_r[tp::I_ROLE])
                      ? tp::M_NORM : tp::M_STBY;
        tp::M_STBY:
          if (go_wr)
            mode_r <= tp::M_NORM;
        tp::M_NORM:
          mode_r <= tp::M_NORM;
        default:
          mode_r <= tp::M_RESET;
      endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      auto_r  <= 1'b0;
      role_r  <= 1'b0;
      rmii_r  <= 1'b0;
      apdis_r <= 1'b0;
      jab_r   <= tp::JAB_DEF;
    end
    else if (mode_r == tp::M_RESET)
    begin
      auto_r  <= rst_done && pin2_r[tp::I_AUTO];
      role_r  <= rst_done && pin2_r[tp::I_ROLE];
      rmii_r  <= rst_done && pin2_r[tp::I_RMII];
      apdis_r <= 1'b0;
      jab_r   <= tp::JAB_DEF;
    end
    else if (wr_ok)
      case (reg_addr)
        tp::OFS_AUTO: auto_r  <= reg_wdata[tp::B_AUTO];
        tp::OFS_ROLE: role_r  <= reg_wdata[tp::B_ROLE];
        tp::OFS_POL:  apdis_r <= reg_wdata[tp::B_APDIS];
        tp::OFS_JAB:  jab_r   <= reg_wdata[10:0];
        default:      jab_r   <= jab_r;
      endcase
  end

  // Read port; management keeps working in standby
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        case (reg_addr)
          tp::OFS_BASIC: reg_rdata <= {mode_r == tp::M_RESET, 15'h0000};
          tp::OFS_AUTO:  reg_rdata <= {6'h00, mode_r == tp::M_NORM,
                                       mode_r == tp::M_STBY, 1'b0, auto_r, 6'h00};
          tp::OFS_JAB:   reg_rdata <= {5'h00, jab_r};
          tp::OFS_POL:   reg_rdata <= {13'h0000, back2_r, apdis_r};
          tp::OFS_ROLE:  reg_rdata <= {1'b0, role_r, 14'h0000};
          default:       reg_rdata <= 16'h0000;
        endcase
    end
  end

  // PCS and PMA only in normal mode
  assign pcs_en = (mode_r == tp::M_NORM);

  // ---- Link clock domain ----
  logic [3:0]  l1_r;
  logic [3:0]  l2_r;
  logic [10:0] j1_r;
  logic [10:0] j2_r;
  logic [10:0] j3_r;
  logic [10:0] jab_l_r;
  logic        run_l;
  logic        master_l;
  logic        rmii_l;
  logic        apdis_l;

  // Config levels cross by two flops each
  always_ff @(posedge link_clk)
  begin
    l1_r <= {apdis_r, rmii_r, role_r, pcs_en};
    l2_r <= l1_r;
  end

  assign run_l    = l2_r[0];
  assign master_l = l2_r[1];
  assign rmii_l   = l2_r[2];
  assign apdis_l  = l2_r[3];

  // Jabber word is taken only when two samples agree, so a
  // half-changed word is never used
  always_ff @(posedge link_clk)
  begin
    j1_r <= jab_r;
    j2_r <= j1_r;
    j3_r <= j2_r;
    if (j2_r == j3_r)
      jab_l_r <= j3_r;
  end

  tp::rx_t     rx_st;
  logic [16:0] jab_cnt_r;
  logic [16:0] jab_lim;
  logic        jab_hit;
  logic [3:0]  rx_d_r;
  logic        tx_ph_r;
  logic [1:0]  tx_lo_r;

  assign jab_lim = 17'(jab_l_r * LINK_MHZ);
  assign jab_hit = (rx_st == tp::RX_DATA) && (jab_cnt_r >= jab_lim);

  always_ff @(posedge link_clk)
  begin
    if (!run_l)
      rx_st <= tp::RX_IDLE;
    else
      case (rx_st)
        tp::RX_IDLE: if (line_ssd) rx_st <= tp::RX_DATA;
        tp::RX_DATA: if (line_esd || jab_hit) rx_st <= tp::RX_IDLE;
        default:     rx_st <= tp::RX_IDLE;
      endcase
  end

  always_ff @(posedge link_clk)
  begin
    if (!run_l || rx_st != tp::RX_DATA)
      jab_cnt_r <= 17'h00000;
    else
      jab_cnt_r <= jab_cnt_r + 17'h00001;
  end

  always_ff @(posedge link_clk)
  begin
    if (!run_l)
    begin
      rx_dv  <= 1'b0;
      rx_er  <= 1'b0;
      rx_d_r <= tp::NIB_IDLE;
    end
    else if (line_stb)
    begin
      if (rx_st == tp::RX_DATA && !line_esd && !jab_hit)
      begin
        rx_dv  <= 1'b1;
        rx_er  <= line_err;
        rx_d_r <= line_nib;
      end
      else
      begin
        rx_dv  <= 1'b0;
        rx_er  <= line_fc;
        rx_d_r <= line_fc ? tp::NIB_FC : tp::NIB_IDLE;
      end
    end
    else if (rmii_l)
      rx_d_r <= {2'h0, rx_d_r[3:2]};
  end

  assign rx_d   = rmii_l ? {2'h0, rx_d_r[1:0]} : rx_d_r;
  assign crs_dv = rx_dv;
  // enables the 50 MHz output on data bit 3
  assign rx_d3_clk_en = rmii_l && master_l;

  always_ff @(posedge link_clk)
  begin
    if (!run_l)
    begin
      pcs_tx_stb <= 1'b0;
      pcs_tx_en  <= 1'b0;
      pcs_tx_er  <= 1'b0;
      pcs_tx_nib <= 4'h0;
      tx_ph_r    <= 1'b0;
      tx_lo_r    <= 2'h0;
    end
    else if (!rmii_l)
    begin
      pcs_tx_stb <= tx_en;
      pcs_tx_en  <= tx_en;
      pcs_tx_er  <= tx_en && tx_er;
      pcs_tx_nib <= tx_d;
    end
    else
    begin
      pcs_tx_en <= tx_en;
      pcs_tx_er <= 1'b0;
      if (!tx_en)
      begin
        tx_ph_r    <= 1'b0;
        pcs_tx_stb <= 1'b0;
      end
      else if (!tx_ph_r)
      begin
        tx_lo_r    <= tx_d[1:0];
        tx_ph_r    <= 1'b1;
        pcs_tx_stb <= 1'b0;
      end
      else
      begin
        pcs_tx_nib <= {tx_d[1:0], tx_lo_r};
        tx_ph_r    <= 1'b0;
        pcs_tx_stb <= 1'b1;
      end
    end
  end

  logic [2:0] ord_cnt_r;
  logic       ord_ba_r;
  logic       ord_lk_r;
  logic [2:0] pol_cnt_r;
  logic       pinv_r;
  logic       pol_lk_r;
  logic       vote_ab;
  logic       vote_ba;
  logic [1:0] sym_a;
  logic       pol_on;

  assign vote_ab = (rx_pair_in[3:2] != tp::SYM_ZERO) && (rx_pair_in[1:0] == tp::SYM_ZERO);
  assign vote_ba = (rx_pair_in[1:0] != tp::SYM_ZERO) && (rx_pair_in[3:2] == tp::SYM_ZERO);
  assign sym_a   = ord_ba_r ? rx_pair_in[1:0] : rx_pair_in[3:2];

  // order vote; a changed vote restarts the count
  always_ff @(posedge link_clk)
  begin
    if (!run_l)
    begin
      ord_cnt_r <= 3'h0;
      ord_ba_r  <= 1'b0;
      ord_lk_r  <= 1'b0;
    end
    else if (train_active && !ord_lk_r && (vote_ab || vote_ba))
    begin
      if (vote_ba != ord_ba_r)
      begin
        ord_ba_r  <= vote_ba;
        ord_cnt_r <= 3'h0;
      end
      else if (ord_cnt_r == tp::LOCK_VOTES)
        ord_lk_r <= 1'b1;
      else
        ord_cnt_r <= ord_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge link_clk)
  begin
    rx_pair_out <= ord_ba_r ? {rx_pair_in[1:0], rx_pair_in[3:2]} : rx_pair_in;
  end

  assign pol_on = train_active && !master_l && !apdis_l && ord_lk_r && !pol_lk_r
                  && (sym_a == tp::SYM_POS || sym_a == tp::SYM_NEG);

  always_ff @(posedge link_clk)
  begin
    if (!run_l || master_l || apdis_l)
    begin
      pol_cnt_r <= 3'h0;
      pinv_r    <= 1'b0;
      pol_lk_r  <= 1'b0;
    end
    else if (pol_on)
    begin
      if ((sym_a == tp::SYM_NEG) != pinv_r)
      begin
        pinv_r    <= (sym_a == tp::SYM_NEG);
        pol_cnt_r <= 3'h0;
      end
      else if (pol_cnt_r == tp::LOCK_VOTES)
        pol_lk_r <= 1'b1;
      else
        pol_cnt_r <= pol_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge link_clk)
  begin
    tx_pair_out <= pinv_r ? {neg_sym(tx_pair_in[3:2]), neg_sym(tx_pair_in[1:0])}
                          : tx_pair_in;
  end

  // Status back to the register side
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      back1_r <= 2'h0;
      back2_r <= 2'h0;
    end
    else
    begin
      back1_r <= {ord_ba_r, pinv_r};
      back2_r <= back1_r;
    end
  end

  // ---- Checks ----
  soft_reset_a: assert property (@(posedge sys_clk) disable iff (reset)
    soft_wr |=> mode_r == tp::M_RESET ##1 mode_r == tp::M_RESET)
    else $error("soft reset not taken");
  // A pulse shorter than the minimum is legal and must not reset, so key on the count
  pin_reset_a: assert property (@(posedge sys_clk) disable iff (reset)
    !pin2_r[tp::I_RSTN] && low_cnt_r == tp::RST_MIN_CYC |=> mode_r == tp::M_RESET)
    else $error("reset pin ignored");
  reg_default_a: assert property (@(posedge sys_clk) disable iff (reset)
    mode_r == tp::M_RESET && $past(mode_r) == tp::M_RESET
    |-> jab_r == tp::JAB_DEF && !apdis_r)
    else $error("register not at default in reset");
  strap_load_a: assert property (@(posedge sys_clk) disable iff (reset)
    rst_done |=> role_r == $past(pin2_r[tp::I_ROLE]) && auto_r == $past(pin2_r[tp::I_AUTO]))
    else $error("strap not loaded");
  standby_entry_a: assert property (@(posedge sys_clk) disable iff (reset)
    rst_done && !pin2_r[tp::I_AUTO] && pin2_r[tp::I_ROLE] |=> mode_r == tp::M_STBY)
    else $error("standby not entered");
  standby_quiet_a: assert property (@(posedge link_clk) disable iff (reset)
    !run_l |=> !pcs_tx_stb && !pcs_tx_en && !rx_dv)
    else $error("data in standby");
  auto_normal_a: assert property (@(posedge sys_clk) disable iff (reset)
    rst_done && pin2_r[tp::I_AUTO] |=> pcs_en)
    else $error("autonomous not normal");
  leave_standby_a: assert property (@(posedge sys_clk) disable iff (reset)
    mode_r == tp::M_STBY && go_wr && !rst_src |=> pcs_en)
    else $error("standby exit lost");
  jabber_idle_a: assert property (@(posedge link_clk) disable iff (!run_l)
    jab_hit |=> rx_st == tp::RX_IDLE && !rx_dv)
    else $error("jabber did not end data");
  false_car_a: assert property (@(posedge link_clk) disable iff (!run_l)
    !rx_dv && rx_er |-> rx_d_r == tp::NIB_FC)
    else $error("bad false carrier code");
  pol_invert_a: assert property (@(posedge link_clk) disable iff (!run_l)
    pinv_r && tx_pair_in == {tp::SYM_POS, tp::SYM_NEG} |=> tx_pair_out == {tp::SYM_NEG, tp::SYM_POS})
    else $error("transmit not inverted");

  stby_exit_c: cover property (@(posedge sys_clk) mode_r == tp::M_STBY ##1 pcs_en);
  jabber_c: cover property (@(posedge link_clk) jab_hit);
  pol_rev_c: cover property (@(posedge link_clk) $rose(pinv_r));
  ord_ba_c: cover property (@(posedge link_clk) ord_lk_r && ord_ba_r);

endmodule : t1_phy_mode

// *** t1_phy_mode_test.sv ***
// Self-checking bench for the mode controller and its MII port.
// Assumes the bench drives straps and reset pin; a MAC model on transmit, bench as PCS.
`timescale 1ns/100ps
module t1_phy_mode_test;
  logic        sys_clk        = 1'b0;
  logic        link_clk       = 1'b0;
  logic        reset          = 1'b1;
  logic        role_strap_pin = 1'b1;
  logic        auto_strap_pin = 1'b0;
  logic        rmii_strap_pin = 1'b0;
  logic        reset_n_pin    = 1'b1;
  logic [15:0] reg_addr       = 16'h0000;
  logic [15:0] reg_wdata      = 16'h0000;
  logic        reg_wr         = 1'b0;
  logic        reg_rd         = 1'b0;
  logic        line_stb       = 1'b0;
  logic        line_ssd       = 1'b0;
  logic        line_esd       = 1'b0;
  logic        line_err       = 1'b0;
  logic        line_fc        = 1'b0;
  logic [3:0]  line_nib       = 4'h0;
  logic        train_active   = 1'b0;
  logic [3:0]  rx_pair_in     = 4'h0;
  logic [3:0]  tx_pair_in     = 4'h0;
  logic        mac_go         = 1'b0;
  logic [31:0] mac_word       = 32'h0;
  logic [15:0] reg_rdata;
  logic        reg_rvalid, pcs_en, tx_en, tx_er, rx_dv, rx_er, pcs_tx_er, pcs_tx_stb, mac_busy;
  logic [3:0]  tx_d, rx_d, pcs_tx_nib, tx_pair_out, rx_pair_out;
  logic        crs_dv, pcs_tx_en, rx_d3_clk_en;
  logic [4:0]  txq[$];
  logic [4:0]  rxq[$];
  logic [3:0]  sent[80];
  int          num_errors = 0;
  int          checks     = 0;

  // bench supplies the link reference; 25 MHz system, 8 MHz link, unrelated
  always #20 sys_clk = ~sys_clk;
  always #62.5 link_clk = ~link_clk;

  t1_phy_mode dut (
    .sys_clk(sys_clk), .reset(reset), .reset_n_pin(reset_n_pin), .supplies_ok(1'b1),
    .role_strap_pin(role_strap_pin), .auto_strap_pin(auto_strap_pin),
    .rmii_strap_pin(rmii_strap_pin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pcs_en(pcs_en), .link_clk(link_clk),
    .tx_en(tx_en), .tx_er(tx_er), .tx_d(tx_d), .rx_dv(rx_dv), .rx_er(rx_er), .crs_dv(crs_dv),
    .rx_d(rx_d), .rx_d3_clk_en(rx_d3_clk_en), .pcs_tx_nib(pcs_tx_nib), .pcs_tx_en(pcs_tx_en),
    .pcs_tx_er(pcs_tx_er), .pcs_tx_stb(pcs_tx_stb), .line_stb(line_stb),
    .line_ssd(line_ssd), .line_esd(line_esd), .line_err(line_err), .line_fc(line_fc),
    .line_nib(line_nib), .train_active(train_active), .rx_pair_in(rx_pair_in),
    .rx_pair_out(rx_pair_out), .tx_pair_in(tx_pair_in), .tx_pair_out(tx_pair_out)
  );

  mac_model mac (
    .link_clk(link_clk), .rmii(rmii_strap_pin), .go(mac_go), .word(mac_word), .err_pos(4'h2),
    .tx_en(tx_en), .tx_er(tx_er), .tx_d(tx_d), .busy(mac_busy)
  );

  // Collect what leaves toward the PCS and toward the MAC
  always @(posedge link_clk)
  begin
    if (pcs_tx_stb === 1'b1 && pcs_tx_en === 1'b1)
      txq.push_back({pcs_tx_er, pcs_tx_nib});
    if (rx_dv === 1'b1 && crs_dv === 1'b1)
      rxq.push_back({rx_er, rx_d});
  end

  task automatic give_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
    int n;
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++)
      @(posedge sys_clk) #1;
    d = reg_rdata;
  endtask : rd_reg

  // Poll until the internal reset state is over; bounded
  task automatic wait_ready();
    logic [15:0] d;
    d = 16'hFFFF;
    for (int n = 0; n < 60 && d[tp::B_SRST] !== 1'b0; n++)
      rd_reg(tp::OFS_BASIC, d);
    check(16'(d[tp::B_SRST]), 16'h0000);
  endtask : wait_ready

  task automatic send_word(input logic [31:0] w);
    int n;
    txq.delete();
    @(posedge link_clk);
    mac_word <= w;
    mac_go   <= 1'b1;
    for (n = 0; n < 8 && mac_busy !== 1'b1; n++)
      @(posedge link_clk);
    mac_go <= 1'b0;
    for (n = 0; n < 40 && mac_busy === 1'b1; n++)
      @(posedge link_clk);
    repeat (4) @(posedge link_clk);
  endtask : send_word

  // Frame from the PCS side; the fourth nibble carries a line error
  task automatic rx_frame(input int n, input logic esd);
    rxq.delete();
    @(posedge link_clk);
    line_ssd <= 1'b1;
    line_stb <= 1'b0;
    @(posedge link_clk);
    line_ssd <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      line_stb <= 1'b1;
      line_nib <= sent[i];
      line_err <= (i == 3);
      @(posedge link_clk);
    end
    line_err <= 1'b0;
    line_esd <= esd;
    @(posedge link_clk);
    line_esd <= 1'b0;
    repeat (4) @(posedge link_clk);
  endtask : rx_frame

  // Idle code check after a few idle strobes
  task automatic idle_code(input logic fc, input logic [5:0] want);
    @(posedge link_clk);
    line_fc <= fc;
    repeat (4) @(posedge link_clk);
    #1;
    check(16'({rx_dv, rx_er, rx_d}), 16'(want));
  endtask : idle_code

  // Hang guard: the whole run needs well under half a millisecond
  initial
  begin
    #1000000;
    num_errors++;
    give_verdict();
  end

  initial
  begin
    logic [15:0] d;
    logic [31:0] w;
    void'($urandom(51));
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    wait_ready();
    rd_reg(tp::OFS_JAB, d);
    check(d & 16'h07FF, 16'(tp::JAB_DEF));
    rd_reg(tp::OFS_ROLE, d);
    check(16'(d[tp::B_ROLE]), 16'h0001);
    rd_reg(tp::OFS_AUTO, d);
    check(16'(d[tp::B_STBY]), 16'h0001);
    rd_reg(16'h0123, d);
    check(d, 16'h0000);
    check(16'(pcs_en), 16'h0000);
    w = $urandom();
    send_word(w);
    check(16'(txq.size()), 16'h0000);
    // Leave standby by command, then send data
    wr_reg(tp::OFS_AUTO, 16'h0001);
    repeat (2) @(posedge sys_clk) #1;
    check(16'(pcs_en), 16'h0001);
    rd_reg(tp::OFS_AUTO, d);
    check(16'(d[tp::B_NORM]), 16'h0001);
    repeat (6) @(posedge link_clk);
    send_word(32'hF0A5_0C3F);
    send_word(w);
    check(16'(txq.size()), 16'h0008);
    for (int i = 0; i < 8; i++)
      check(16'(txq[i]), 16'({i == 2, w[4*i+:4]}));
    // Random receive frame with corner nibbles at the ends
    for (int i = 0; i < 80; i++)
      sent[i] = 4'($urandom());
    sent[0] = 4'hF;
    sent[9] = 4'h0;
    rx_frame(10, 1'b1);
    check(16'(rxq.size()), 16'h000A);
    for (int i = 0; i < 10; i++)
      check(16'(rxq[i]), 16'({i == 3, sent[i]}));
    idle_code(1'b1, {2'b01, tp::NIB_FC});
    idle_code(1'b0, {2'b00, tp::NIB_IDLE});
    // Short jabber limit: 2 units of 25 link cycles, so 50 nibbles pass before the cut
    wr_reg(tp::OFS_JAB, 16'h0002);
    repeat (6) @(posedge link_clk);
    rx_frame(80, 1'b0);
    check(16'(rxq.size()), 16'h0032);
    check(16'(rx_dv), 16'h0000);
    // Software reset restores defaults and re-enters standby
    wr_reg(tp::OFS_BASIC, 16'h8000);
    rd_reg(tp::OFS_BASIC, d);
    check(16'(d[tp::B_SRST]), 16'h0001);
    wait_ready();
    rd_reg(tp::OFS_JAB, d);
    check(d & 16'h07FF, 16'(tp::JAB_DEF));
    check(16'(pcs_en), 16'h0000);
    wr_reg(tp::OFS_AUTO, 16'h0040);
    repeat (2) @(posedge sys_clk) #1;
    check(16'(pcs_en), 16'h0001);
    wr_reg(tp::OFS_ROLE, 16'h0000);
    rd_reg(tp::OFS_ROLE, d);
    check(16'(d[tp::B_ROLE]), 16'h0000);
    wr_reg(tp::OFS_ROLE, 16'h4000);
    rd_reg(tp::OFS_ROLE, d);
    check(16'(d[tp::B_ROLE]), 16'h0001);
    // Slave by strap; the written master bit must not survive the reset
    @(posedge sys_clk);
    role_strap_pin <= 1'b0;
    wr_reg(tp::OFS_BASIC, 16'h8000);
    wait_ready();
    rd_reg(tp::OFS_ROLE, d);
    check(16'(d[tp::B_ROLE]), 16'h0000);
    // Partner in B-A order with reversed polarity during training
    @(posedge link_clk);
    train_active <= 1'b1;
    rx_pair_in   <= {tp::SYM_ZERO, tp::SYM_NEG};
    tx_pair_in   <= {tp::SYM_POS, tp::SYM_NEG};
    repeat (20) @(posedge link_clk);
    train_active <= 1'b0;
    repeat (4) @(posedge link_clk) #1;
    check(16'(tx_pair_out), 16'({tp::SYM_NEG, tp::SYM_POS}));
    check(16'(rx_pair_out), 16'({tp::SYM_NEG, tp::SYM_ZERO}));
    rd_reg(tp::OFS_POL, d);
    check(16'(d[tp::B_PINV]), 16'h0001);
    check(16'(d[tp::B_ORD]), 16'h0001);
    wr_reg(tp::OFS_POL, 16'h0001);
    repeat (6) @(posedge link_clk) #1;
    check(16'(tx_pair_out), 16'({tp::SYM_POS, tp::SYM_NEG}));
    // RMII slave by strap: dibit pairs reach the PCS as whole nibbles
    @(posedge sys_clk);
    rmii_strap_pin <= 1'b1;
    wr_reg(tp::OFS_BASIC, 16'h8000);
    wait_ready();
    w = $urandom();
    send_word(w);
    check(16'(txq.size()), 16'h0008);
    for (int i = 0; i < 8; i++)
      check(16'(txq[i]), 16'({1'b0, w[4*i+:4]}));
    check(16'(rx_d3_clk_en), 16'h0000);
    wr_reg(tp::OFS_ROLE, 16'h4000);
    repeat (4) @(posedge link_clk) #1;
    check(16'(rx_d3_clk_en), 16'h0001);
    // Reset pin with autonomous master straps ends in normal mode unasked
    @(posedge sys_clk);
    role_strap_pin <= 1'b1;
    auto_strap_pin <= 1'b1;
    rmii_strap_pin <= 1'b0;
    reset_n_pin    <= 1'b0;
    repeat (40) @(posedge sys_clk);
    reset_n_pin <= 1'b1;
    wait_ready();
    rd_reg(tp::OFS_AUTO, d);
    check(16'(d[tp::B_AUTO]), 16'h0001);
    check(16'(d[tp::B_NORM]), 16'h0001);
    check(16'(pcs_en), 16'h0001);
    give_verdict();
  end
endmodule : t1_phy_mode_test

// *** tp.sv ***
// Constants shared by the mode controller and its MAC-side port.
// Assumes a 25 MHz system clock and 2-bit ternary codes from the line.
package tp;
  // Register offsets on the management port
  localparam logic [15:0] OFS_BASIC = 16'h001F;
  localparam logic [15:0] OFS_AUTO  = 16'h018B;
  localparam logic [15:0] OFS_JAB   = 16'h0496;
  localparam logic [15:0] OFS_POL   = 16'h0553;
  localparam logic [15:0] OFS_ROLE  = 16'h1834;
  // Field positions
  localparam int B_SRST  = 15;
  localparam int B_AUTO  = 6;
  localparam int B_GO    = 0;
  localparam int B_STBY  = 8;
  localparam int B_NORM  = 9;
  localparam int B_ROLE  = 14;
  localparam int B_APDIS = 0;
  localparam int B_PINV  = 1;
  localparam int B_ORD   = 2;
  // Reset values
  localparam logic [10:0] JAB_DEF = 11'h44C;  // 1100 us
  localparam logic [4:0]  PIN_RST = 5'h18;    // Supplies up, reset pin high
  // Pin vector positions
  localparam int I_ROLE = 0;
  localparam int I_AUTO = 1;
  localparam int I_RMII = 2;
  localparam int I_RSTN = 3;
  localparam int I_SUP  = 4;
  // Timing
  localparam int SYS_NS     = 40;
  localparam int RST_MIN_NS = 1000;
  localparam logic [7:0] RST_MIN_CYC = 8'((RST_MIN_NS + SYS_NS - 1) / SYS_NS);
  localparam logic [4:0] RST_HOLD = 5'h10;
  localparam logic [2:0] LOCK_VOTES = 3'h7;
  // Line codes and MII receive codes
  localparam logic [1:0] SYM_ZERO = 2'h0;
  localparam logic [1:0] SYM_POS  = 2'h1;
  localparam logic [1:0] SYM_NEG  = 2'h3;
  localparam logic [3:0] NIB_FC   = 4'hE;
  localparam logic [3:0] NIB_IDLE = 4'h0;
  // States
  typedef enum logic [1:0] {M_RESET, M_STBY, M_NORM} mode_t;
  typedef enum logic {RX_IDLE, RX_DATA} rx_t;
endpackage : tp
